//--- core/dspwm_top.v
// dual-slope pwm output stage: counter, compare channels, pin override and registers
// Operation
// - overflow flag set at every bottom
// - mode two non-inverted, three inverted pwm
// - channel a mode one gives complementary pair
// - match clears rising, sets falling
// - period spans twice top steps
// - top at bottom low, max high
// - pwm drives pin only if mode, dir
// - channel b true output on bit3
// - channel b inverted output on bit2
// - channel a true output on bit1
// - channel a inverted output on bit0
// - channel d inverted output on bit4
`timescale 1ns/1ns
`include "dspwm_defs.vh"
module dspwm_top #(
	parameter CW = 10
) (
	// clock and reset
	input wire core_clk_in,
	input wire nrst_in,
	// peripheral timer tick, may be asynchronous
	input wire timer_tick_in,
	// register port
	input wire [`DSPWM_ADDR_W-1:0] addr_in,
	input wire [CW-1:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [CW-1:0] rdata_out,
	// interrupt
	output reg irq_out,
	// port b pins bits 0..4
	output reg [4:0] port_b_out,
	output reg [4:0] port_b_oe_out
);
	// ============================================================
	// constants
	// counter step of one at full counter width, keeps the arithmetic width-clean
	localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};
	// all-ones counter value, the top at which outputs are held high
	localparam [CW-1:0] CNT_MAX = {CW{1'b1}};
	// ============================================================
	// reset release
	// two flops so that release never lands close to an edge inside the block
	reg rst1_q;
	reg rst2_q; // released reset, active high level means running
	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst1_q <= 1'b0;
			rst2_q <= 1'b0;
		end else begin
			rst1_q <= 1'b1;
			rst2_q <= rst1_q;
		end
	end
	wire rst_n = rst2_q;
	// ============================================================
	// software-facing registers
	reg [CW-1:0] cmp_a_q; // channel a compare
	reg [CW-1:0] cmp_b_q; // channel b compare
	reg [CW-1:0] top_q; // top compare register
	reg [CW-1:0] cmp_d_q; // channel d compare
	reg [6:0] mode_q; // output modes and run bit
	reg [4:0] port_q; // general port value
	reg [4:0] dir_q; // pin directions
	reg irq_en_q; // overflow interrupt enable
	reg ovf_stat_q; // sticky overflow status
	// ============================================================
	// timer domain shadows (input synchronisation stage)
	reg [CW-1:0] cmp_a_si_q;
	reg [CW-1:0] cmp_b_si_q;
	reg [CW-1:0] top_si_q;
	reg [CW-1:0] cmp_d_si_q;
	reg [6:0] mode_si_q;
	// ============================================================
	// counter state and output synchronisation stage
	reg [CW-1:0] pwm_counter_value_q;
	reg count_down_q; // direction: 1 while decrementing
	reg [CW-1:0] count_so_q; // counter copy seen by software
	reg [2:0] wave_q; // internal waveforms a, b, d (non-inverted)
	reg ovf_evt_q; // one-cycle bottom event
	wire tick_sync;
	reg tick_prev_q;
	wire step = tick_sync & ~tick_prev_q & mode_si_q[`DSPWM_MODE_RUN_BIT];
	// one rising edge of the filtered tick is one counter step, only while running
	// tick pin crosses through three sync flops and the filter output flop
	dspwm_sync3 #(.W(1)) u_tick_sync (
		.clk_in(core_clk_in),
		.nrst_in(rst_n),
		.d_in(timer_tick_in),
		.q_out(tick_sync)
	);
	// ============================================================
	// register writes and sticky status
	// writes land in the strobe cycle; counter and status offsets are read-only
	// a write to an unmapped offset changes nothing
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cmp_a_q <= `DSPWM_RST_CMP;
			cmp_b_q <= `DSPWM_RST_CMP;
			cmp_d_q <= `DSPWM_RST_CMP;
			top_q <= `DSPWM_RST_TOP;
			mode_q <= `DSPWM_RST_MODE;
			port_q <= `DSPWM_RST_PORT;
			dir_q <= `DSPWM_RST_PORT;
			irq_en_q <= 1'b0;
			ovf_stat_q <= 1'b0;
		end else begin
			// address decode
			if (wr_in && addr_in == `DSPWM_OFS_CMP_A) begin
				cmp_a_q <= wdata_in;
			end else if (wr_in && addr_in == `DSPWM_OFS_CMP_B) begin
				cmp_b_q <= wdata_in;
			end else if (wr_in && addr_in == `DSPWM_OFS_TOP) begin
				top_q <= wdata_in;
			end else if (wr_in && addr_in == `DSPWM_OFS_CMP_D) begin
				cmp_d_q <= wdata_in;
			end else if (wr_in && addr_in == `DSPWM_OFS_MODE) begin
				mode_q <= wdata_in[6:0];
			end else if (wr_in && addr_in == `DSPWM_OFS_PORT) begin
				port_q <= wdata_in[4:0];
			end else if (wr_in && addr_in == `DSPWM_OFS_DIR) begin
				dir_q <= wdata_in[4:0];
			end else if (wr_in && addr_in == `DSPWM_OFS_IRQ_EN) begin
				irq_en_q <= wdata_in[0];
			end
			// clear register is write-only: a one in bit 0 drops the flag
			// set wins over clear in the same cycle
			if (ovf_evt_q) begin
				ovf_stat_q <= 1'b1;
			end else if (wr_in && addr_in == `DSPWM_OFS_IRQ_CLR && wdata_in[0]) begin
				ovf_stat_q <= 1'b0;
			end
		end
	end
	// ============================================================
	// read port, data one cycle after the strobe; unmapped reads zero
	// the strobe gates the data, so the bus sees zero between reads
	// count comes from the output copy, one clock behind the live counter
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_out <= {CW{1'b0}};
		end else if (!rd_in) begin
			rdata_out <= {CW{1'b0}};
		end else if (addr_in == `DSPWM_OFS_CMP_A) begin
			rdata_out <= cmp_a_q;
		end else if (addr_in == `DSPWM_OFS_CMP_B) begin
			rdata_out <= cmp_b_q;
		end else if (addr_in == `DSPWM_OFS_TOP) begin
			rdata_out <= top_q;
		end else if (addr_in == `DSPWM_OFS_CMP_D) begin
			rdata_out <= cmp_d_q;
		end else if (addr_in == `DSPWM_OFS_MODE) begin
			rdata_out <= {{(CW-7){1'b0}}, mode_q};
		end else if (addr_in == `DSPWM_OFS_PORT) begin
			rdata_out <= {{(CW-5){1'b0}}, port_q};
		end else if (addr_in == `DSPWM_OFS_DIR) begin
			rdata_out <= {{(CW-5){1'b0}}, dir_q};
		end else if (addr_in == `DSPWM_OFS_COUNT) begin
			rdata_out <= count_so_q;
		end else if (addr_in == `DSPWM_OFS_IRQ_STAT) begin
			rdata_out <= {{(CW-1){1'b0}}, ovf_stat_q};
		end else if (addr_in == `DSPWM_OFS_IRQ_EN) begin
			rdata_out <= {{(CW-1){1'b0}}, irq_en_q};
		end else begin
			rdata_out <= {CW{1'b0}};
		end
	end
	// ============================================================
	// input stage: compare and top shadows reload only at bottom while running so a period never tears
	// hazard: loading compares mid-period could leave a runt pulse on a pin
	// trade-off: a new value waits up to a whole period while running
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cmp_a_si_q <= `DSPWM_RST_CMP;
			cmp_b_si_q <= `DSPWM_RST_CMP;
			cmp_d_si_q <= `DSPWM_RST_CMP;
			top_si_q <= `DSPWM_RST_TOP;
			mode_si_q <= `DSPWM_RST_MODE;
		end else begin
			mode_si_q <= mode_q;
			// compare values follow while stopped, else at bottom
			if (!mode_si_q[`DSPWM_MODE_RUN_BIT] ||
				(step && count_down_q && pwm_counter_value_q == {{(CW-1){1'b0}}, 1'b1})) begin
				cmp_a_si_q <= cmp_a_q;
				cmp_b_si_q <= cmp_b_q;
				cmp_d_si_q <= cmp_d_q;
				top_si_q <= top_q;
			end
		end
	end
	// ============================================================
	// dual-slope counter: up to top, down to bottom
	// limitation: a step needs a filtered tick edge, so at most one every few clocks
	// the counter only moves while the run bit is set in the timer domain
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pwm_counter_value_q <= {CW{1'b0}};
			count_down_q <= 1'b0;
			tick_prev_q <= 1'b0;
			ovf_evt_q <= 1'b0;
			count_so_q <= {CW{1'b0}};
		end else begin
			tick_prev_q <= tick_sync;
			count_so_q <= pwm_counter_value_q;
			ovf_evt_q <= 1'b0;
			if (step) begin
				if (top_si_q == {CW{1'b0}}) begin
					// degenerate top: counter parks at bottom
					pwm_counter_value_q <= {CW{1'b0}};
					count_down_q <= 1'b0;
					ovf_evt_q <= 1'b1;
				end else if (!count_down_q) begin
					// turn one step early so that top itself is the peak value
					if (pwm_counter_value_q >= top_si_q - CNT_ONE) begin
						count_down_q <= 1'b1;
					end
					pwm_counter_value_q <= pwm_counter_value_q + CNT_ONE;
				end else begin
					// bottom is the step that lands on zero
					if (pwm_counter_value_q == CNT_ONE) begin
						count_down_q <= 1'b0;
						ovf_evt_q <= 1'b1;
					end
					pwm_counter_value_q <= pwm_counter_value_q - CNT_ONE;
				end
			end
		end
	end
	// ============================================================
	// compare per channel: clear on up match, set on down match
	// each channel keeps one wave flop; pin polarity is applied further on
	wire [3*CW-1:0] cmp_all = {cmp_d_si_q, cmp_b_si_q, cmp_a_si_q};
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
			always @(posedge core_clk_in or negedge rst_n) begin
				if (!rst_n) begin
					wave_q[ch] <= 1'b0;
				end else if (top_si_q == {CW{1'b0}}) begin
					wave_q[ch] <= 1'b0;
				end else if (top_si_q == CNT_MAX) begin
					// extremes of top override the compares entirely
					wave_q[ch] <= 1'b1;
				end else if (step && pwm_counter_value_q == cmp_all[ch*CW +: CW]) begin
					wave_q[ch] <= count_down_q;
				end
			end
		end
	endgenerate
	// ============================================================
	// output mode decode and pin override
	wire [1:0] om_a = mode_si_q[`DSPWM_MODE_A_LSB +: 2];
	wire [1:0] om_b = mode_si_q[`DSPWM_MODE_B_LSB +: 2];
	wire [1:0] om_d = mode_si_q[`DSPWM_MODE_D_LSB +: 2];
	// true and inverted outputs per channel; mode three flips polarity
	wire a_true = (om_a == `DSPWM_OM_INV) ? ~wave_q[0] : wave_q[0];
	wire b_true = (om_b == `DSPWM_OM_INV) ? ~wave_q[1] : wave_q[1];
	wire d_true = (om_d == `DSPWM_OM_INV) ? ~wave_q[2] : wave_q[2];
	// which pins the compare unit claims
	// mode one claims both pins of a pair; modes two and three only the even pin
	reg [4:0] pwm_sel;
	reg [4:0] pwm_val;
	always @* begin
		pwm_sel = 5'h00;
		pwm_val = 5'h00;
		// channel a: true on bit1, inverted on bit0
		pwm_sel[1] = (om_a == `DSPWM_OM_COMPL);
		pwm_sel[0] = (om_a != `DSPWM_OM_OFF);
		pwm_val[1] = a_true;
		pwm_val[0] = (om_a == `DSPWM_OM_COMPL) ? ~a_true : a_true;
		// channel b: true on bit3, inverted on bit2
		pwm_sel[3] = (om_b == `DSPWM_OM_COMPL);
		pwm_sel[2] = (om_b != `DSPWM_OM_OFF);
		pwm_val[3] = b_true;
		pwm_val[2] = (om_b == `DSPWM_OM_COMPL) ? ~b_true : b_true;
		// channel d: inverted pin on bit4 only
		pwm_sel[4] = (om_d != `DSPWM_OM_OFF);
		pwm_val[4] = (om_d == `DSPWM_OM_COMPL) ? ~d_true : d_true;
	end
	// ============================================================
	// registered pins and interrupt
	// every pin and flag leaves a flop, so the outputs never glitch
	// direction drives the enable straight; an input pin is never claimed
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			port_b_out <= 5'h00;
			port_b_oe_out <= 5'h00;
			irq_out <= 1'b0;
		end else begin
			// pwm replaces port value only where direction is output
			port_b_out <= (pwm_sel & dir_q & pwm_val) | (~(pwm_sel & dir_q) & port_q);
			port_b_oe_out <= dir_q;
			// interrupt is a level, high while status and enable are both set
			irq_out <= ovf_stat_q & irq_en_q;
		end
	end
endmodule // dspwm_top

//--- core/dspwm_defs.vh
// register offsets, field positions, reset values and timing constants of the dual-slope pwm stage
`ifndef DSPWM_DEFS_VH
`define DSPWM_DEFS_VH
// ============================================================
// register offsets (register index on the plain port)
`define DSPWM_ADDR_W 4
`define DSPWM_OFS_CMP_A 4'h0
`define DSPWM_OFS_CMP_B 4'h1
`define DSPWM_OFS_TOP 4'h2
`define DSPWM_OFS_CMP_D 4'h3
`define DSPWM_OFS_MODE 4'h4
`define DSPWM_OFS_PORT 4'h5
`define DSPWM_OFS_DIR 4'h6
`define DSPWM_OFS_COUNT 4'h7
`define DSPWM_OFS_IRQ_STAT 4'h8
`define DSPWM_OFS_IRQ_CLR 4'h9
`define DSPWM_OFS_IRQ_EN 4'hA
// ============================================================
// mode register fields
`define DSPWM_MODE_A_LSB 0
`define DSPWM_MODE_B_LSB 2
`define DSPWM_MODE_D_LSB 4
`define DSPWM_MODE_RUN_BIT 6
// ============================================================
// output mode encodings
`define DSPWM_OM_OFF 2'h0
`define DSPWM_OM_COMPL 2'h1
`define DSPWM_OM_NONINV 2'h2
`define DSPWM_OM_INV 2'h3
// ============================================================
// reset values
`define DSPWM_RST_TOP 10'h3FF
`define DSPWM_RST_CMP 10'h000
`define DSPWM_RST_MODE 7'h00
`define DSPWM_RST_PORT 5'h00
// ============================================================
// timing
`define DSPWM_TICK_DIV 8'h01
`endif

//--- core/dspwm_sync3.v
// three-stage input synchroniser with agreement filter for the timer clock domain
`timescale 1ns/1ns
module dspwm_sync3 #(
	parameter W = 1
) (
	// clock and reset
	input wire clk_in,
	input wire nrst_in,
	// data
	input wire [W-1:0] d_in,
	output reg [W-1:0] q_out
);
	reg [W-1:0] s1_q; // first stage, read only by s2
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	// ============================================================
	// shift chain; value accepted once stages two and three agree
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
			s3_q <= {W{1'b0}};
			q_out <= {W{1'b0}};
		end else begin
			s1_q <= d_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				q_out <= s3_q;
			end
		end
	end
endmodule // dspwm_sync3

//--- verification/dspwm_chk.sv
// port-level assertions of the dual-slope pwm output stage
`timescale 1ns/1ns
`include "dspwm_defs.vh"
module dspwm_chk #(
	parameter CW = 10
) (
	// clock and reset
	input wire core_clk_in,
	input wire nrst_in,
	// tick and register port
	input wire timer_tick_in,
	input wire [`DSPWM_ADDR_W-1:0] addr_in,
	input wire [CW-1:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [CW-1:0] rdata_out,
	// outputs
	input wire irq_out,
	input wire [4:0] port_b_out,
	input wire [4:0] port_b_oe_out
);
	// ============================================================
	// shadow of software writes
	reg [6:0] mode_q; // last mode word
	reg [4:0] port_q; // last port value
	reg [4:0] dir_q; // last direction
	reg [CW-1:0] top_q; // last top value
	reg en_q; // irq enable bit
	reg [3:0] quiet_q; // cycles since any write, saturating
	// pins are only judged once the sync stages have drained
	wire settled = quiet_q >= 4'h8;
	wire top0_stop = settled && !mode_q[6] && top_q == 0;
	// track writes
	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mode_q <= 7'h00;
			port_q <= 5'h00;
			dir_q <= 5'h00;
			top_q <= `DSPWM_RST_TOP;
			en_q <= 1'b0;
			quiet_q <= 4'h0;
		end else if (wr_in) begin
			quiet_q <= 4'h0;
			if (addr_in == `DSPWM_OFS_MODE) mode_q <= wdata_in[6:0];
			if (addr_in == `DSPWM_OFS_PORT) port_q <= wdata_in[4:0];
			if (addr_in == `DSPWM_OFS_DIR) dir_q <= wdata_in[4:0];
			if (addr_in == `DSPWM_OFS_TOP) top_q <= wdata_in;
			if (addr_in == `DSPWM_OFS_IRQ_EN) en_q <= wdata_in[0];
		end else if (quiet_q != 4'hF) begin
			quiet_q <= quiet_q + 4'h1;
		end
	end
	// ============================================================
	// assertions
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	chk_read_idle: assert property (!$past(rd_in) |-> rdata_out == 0)
		else $error("read data outside read slot");
	chk_unmapped_zero: assert property ($past(rd_in) && $past(addr_in) > 4'hA |-> rdata_out == 0)
		else $error("unmapped read not zero");
	chk_dir_oe: assert property (settled |-> port_b_oe_out == dir_q)
		else $error("enable differs from direction");
	chk_port_pass: assert property (settled && mode_q[5:0] == 0 |-> port_b_out == port_q)
		else $error("port value not on pins");
	chk_input_pins: assert property (settled |-> ((port_b_out ^ port_q) & ~dir_q) == 0)
		else $error("input pin overridden");
	chk_compl_a: assert property (top0_stop && mode_q[1:0] == 1 && dir_q[1:0] == 3
		|-> port_b_out[1:0] == 2'b01)
		else $error("complementary pair wrong");
	chk_chan_d_pin: assert property (top0_stop && dir_q[4] && mode_q[5:4] != 0
		|-> port_b_out[4] == (mode_q[5:4] != 2))
		else $error("channel d pin wrong");
	chk_irq_mask: assert property (wr_in && addr_in == `DSPWM_OFS_IRQ_EN && !wdata_in[0]
		|-> ##[1:4] !irq_out)
		else $error("masked irq stays high");
	chk_irq_clear: assert property (wr_in && addr_in == `DSPWM_OFS_IRQ_CLR && wdata_in[0] &&
		!mode_q[6] |-> ##[1:4] !irq_out)
		else $error("cleared irq stays high");
	chk_irq_needs_en: assert property ($rose(irq_out) |-> en_q)
		else $error("irq without enable");
endmodule // dspwm_chk
bind dspwm_top dspwm_chk #(.CW(CW)) u_chk (.core_clk_in, .nrst_in, .timer_tick_in, .addr_in,
	.wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out, .port_b_out, .port_b_oe_out);

//--- verification/dspwm_top_bench.sv
// self-checking bench of the dual-slope pwm output stage
`timescale 1ns/1ns
`include "dspwm_defs.vh"
`define CHK(a, b) begin n_compared = n_compared + 1; if ((a) !== (b)) begin \
	miscompares = miscompares + 1; $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module dspwm_top_bench;
	// ============================================================
	// stimulus and observation
	reg core_clk_in = 1'b0;
	reg nrst_in = 1'b0;
	reg timer_tick_in = 1'b0;
	reg [3:0] addr_in = 4'h0;
	reg [9:0] wdata_in = 10'h000;
	reg wr_in = 1'b0;
	reg rd_in = 1'b0;
	wire [9:0] rdata_out;
	wire irq_out;
	wire [4:0] port_b_out;
	wire [4:0] port_b_oe_out;
	integer miscompares = 0;
	integer n_compared = 0;
	integer t, m, i;
	reg [31:0] rnd = 32'h5482; // fixed seed
	reg [9:0] v, prev, ex;
	reg [6:0] md;
	reg [4:0] dr;
	reg up, w;
	dspwm_top #(.CW(10)) DUT (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
		.timer_tick_in(timer_tick_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .port_b_out(port_b_out),
		.port_b_oe_out(port_b_oe_out));
	// 20 mhz clock
	initial forever #25 core_clk_in = ~core_clk_in;
	// ============================================================
	// helpers
	function [31:0] lfsr_next(input [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected pins for one static wave level on all channels
	function [4:0] exp_pins(input [6:0] mo, input [4:0] p, input [4:0] d, input wv);
		reg [4:0] o;
		begin
			o = p;
			if (mo[1:0] == 1) o[1] = wv; // true pin only in complementary mode
			if (mo[1:0] != 0) o[0] = (mo[1:0] == 2) ? wv : ~wv;
			if (mo[3:2] == 1) o[3] = wv;
			if (mo[3:2] != 0) o[2] = (mo[3:2] == 2) ? wv : ~wv;
			if (mo[5:4] != 0) o[4] = (mo[5:4] == 2) ? wv : ~wv;
			exp_pins = (o & d) | (p & ~d); // inputs keep the port value
		end
	endfunction
	task wr(input [3:0] a, input [9:0] d);
		begin
			@(posedge core_clk_in);
			addr_in <= a;
			wdata_in <= d;
			wr_in <= 1'b1;
			@(posedge core_clk_in);
			wr_in <= 1'b0;
		end
	endtask
	// data stand only in the cycle after the strobe
	task rd(input [3:0] a, output [9:0] d);
		begin
			@(posedge core_clk_in);
			addr_in <= a;
			rd_in <= 1'b1;
			@(posedge core_clk_in);
			rd_in <= 1'b0;
			@(negedge core_clk_in);
			d = rdata_out;
		end
	endtask
	// outputs are looked at mid-cycle, away from the edge that moves them
	task settle;
		begin
			repeat (10) @(posedge core_clk_in);
			@(negedge core_clk_in);
		end
	endtask
	// one timer step, wide enough for the agreement filter
	task tick;
		begin
			@(posedge core_clk_in);
			timer_tick_in <= 1'b1;
			repeat (4) @(posedge core_clk_in);
			timer_tick_in <= 1'b0;
			repeat (4) @(posedge core_clk_in);
		end
	endtask
	task stop_test;
		begin
			if (miscompares == 0 && n_compared > 0) $display("All checks passed");
			else $display("Checks failed");
			$finish;
		end
	endtask
	// ============================================================
	// watchdog: the run needs about 610 cycles
	initial begin
		repeat (6000) @(posedge core_clk_in);
		miscompares = miscompares + 1;
		stop_test;
	end
	// ============================================================
	// main sequence
	initial begin
		repeat (16) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		rd(`DSPWM_OFS_TOP, v);
		`CHK(v, `DSPWM_RST_TOP);
		rd(4'hF, v);
		`CHK(v, 10'h000);
		// compare registers of b and d keep what was written
		rnd = lfsr_next(rnd);
		wr(`DSPWM_OFS_CMP_B, rnd[9:0]);
		wr(`DSPWM_OFS_CMP_D, rnd[19:10]);
		rd(`DSPWM_OFS_CMP_B, v);
		`CHK(v, rnd[9:0]);
		rd(`DSPWM_OFS_CMP_D, v);
		`CHK(v, rnd[19:10]);
		// static waves: top at bottom gives low, top at max while stopped gives high
		for (t = 0; t < 2; t = t + 1) begin
			for (m = 0; m < 8; m = m + 1) begin
				rnd = lfsr_next(rnd);
				md = {1'b0, m[1:0], m[1:0], m[1:0]};
				dr = m[2] ? 5'h1F : rnd[9:5];
				wr(`DSPWM_OFS_TOP, t ? 10'h3FF : 10'h000);
				wr(`DSPWM_OFS_MODE, {3'h0, md});
				wr(`DSPWM_OFS_PORT, {5'h00, rnd[4:0]});
				wr(`DSPWM_OFS_DIR, {5'h00, dr});
				settle;
				`CHK(port_b_out, exp_pins(md, rnd[4:0], dr, t[0]));
				`CHK(port_b_oe_out, dr);
			end
		end
		// running: top 4, compare 2, channel a complementary
		wr(`DSPWM_OFS_PORT, 10'h000);
		wr(`DSPWM_OFS_TOP, 10'h004);
		wr(`DSPWM_OFS_CMP_A, 10'h002);
		wr(`DSPWM_OFS_IRQ_EN, 10'h001);
		wr(`DSPWM_OFS_DIR, 10'h003);
		wr(`DSPWM_OFS_MODE, 10'h041);
		prev = 10'h000;
		up = 1'b1;
		for (i = 0; i < 20; i = i + 1) begin
			tick;
			rd(`DSPWM_OFS_COUNT, v);
			if (i == 1) up = v > prev;
			if (i > 1) begin
				if (prev == 4) up = 1'b0;
				else if (prev == 0) up = 1'b1;
				ex = up ? prev + 10'h001 : prev - 10'h001;
				`CHK(v, ex);
				w = (v < 2) || (v == 2 && up);
				`CHK(port_b_out[1:0], {w, ~w});
			end
			prev = v;
		end
		// stop, then status, masking and clearing
		wr(`DSPWM_OFS_MODE, 10'h000);
		settle;
		rd(`DSPWM_OFS_IRQ_STAT, v);
		`CHK(v[0], 1'b1);
		`CHK(irq_out, 1'b1);
		wr(`DSPWM_OFS_COUNT, 10'h3FF);
		rd(`DSPWM_OFS_COUNT, v);
		`CHK(v, prev);
		wr(`DSPWM_OFS_IRQ_EN, 10'h000);
		settle;
		`CHK(irq_out, 1'b0);
		wr(`DSPWM_OFS_IRQ_EN, 10'h001);
		settle;
		`CHK(irq_out, 1'b1);
		wr(`DSPWM_OFS_IRQ_CLR, 10'h001);
		settle;
		rd(`DSPWM_OFS_IRQ_STAT, v);
		`CHK(v[0], 1'b0);
		`CHK(irq_out, 1'b0);
		stop_test;
	end
endmodule // dspwm_top_bench
